/* File: hw/pci_pkg.sv */
// package for the point command i/o block: offsets, fields, resets, timing
// assumes a 100 MHz pclk and a 32-bit apb register bus
package pci_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] PCI_CFG_OFS = 8'h00;
	localparam logic [7:0] PCI_RANGE_OFS = 8'h04;
	localparam logic [7:0] PCI_BRAKE_OFS = 8'h08;
	localparam logic [7:0] PCI_STAT_OFS = 8'h0C;
	localparam logic [7:0] PCI_CMD_OFS = 8'h10;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PCI_CFG_CNT_LSB = 0;
	localparam int PCI_CFG_LOGIC_BIT = 2;
	localparam int PCI_CFG_SEL_BIT = 3;
	localparam int PCI_CFG_HDIS_BIT = 4;
	localparam int PCI_BRK_STILL_LSB = 0;
	localparam int PCI_BRK_MOVE_LSB = 8;
	localparam int PCI_STAT_BUSY_BIT = 6;
	localparam int PCI_STAT_FAULT_BIT = 7;
	localparam int PCI_STAT_STATE_LSB = 8;
	localparam int PCI_PT_BITS = 6;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [4:0] PCI_CFG_RST = 5'h07;
	localparam logic [15:0] PCI_RANGE_RST = 16'h000A;
	localparam logic [15:0] PCI_BRAKE_RST = 16'h0000;
	localparam logic [1:0] PCI_CNT_SIX_BITS = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int PCI_CLK_PERIOD_NS = 10;
	localparam int PCI_MS_TIME_NS = 1000000;
	localparam int PCI_HOST_SETUP_MS = 10;
	localparam int PCI_MS_CYCLES = PCI_MS_TIME_NS / PCI_CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PCI_IDLE = 3'b001,
		PCI_RUN = 3'b010,
		PCI_HOLD = 3'b100
	} pci_state_e;

	typedef enum logic [2:0] {
		PCI_K_CLEAR = 3'h0,
		PCI_K_STEP = 3'h1,
		PCI_K_JOG_NEG = 3'h2,
		PCI_K_JOG_POS = 3'h3,
		PCI_K_HOME = 3'h4
	} pci_kind_e;

endpackage

/* File: hw/pci_sync.sv */
// two-flop synchroniser, one stage pair per bit
// assumes inputs are plain levels from contact inputs
`timescale 1ns/1ns
module pci_sync #(
	parameter int WIDTH = 7
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta;

	// ------------------------------------------------------------
	// per-bit stages; the first flop feeds only the second
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta[i] <= 1'b0;
					dout[i] <= 1'b0;
				end else begin
					meta[i] <= din[i];
					dout[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

/* File: hw/pci_top.sv */
// point command i/o: point decode, strobe handshake, status pins, apb regs
// assumes a motion engine beside it that runs commands and reports back
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
import pci_pkg::*;

// Functional notes
// - point 0 clears alarm, others move
// - top three codes jog neg, pos, home
// - special codes follow configured point count
// - count setting 3 gives six bits
// - pin level one means contact closed
// - logic setting 0 inverts every point bit
// - fault pin on normally, off on alarm
// - setting picks completion or decelerating status
// - decelerating on, not with zero decel time
// - busy pin off while processing command
// - busy stays off until strobe released
// - finished step shows its point number
// - power-on shows 0, or max point
// - homing done shows max point
// - positive jog stop shows max minus 1
// - negative jog stop shows max minus 2
// - alarm forces position outputs off
// - aborted command holds previous position
// - brake pin follows two configurable delays
module pci_top #(
	parameter int MS_CYCLES = PCI_MS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic point_sel_bit0,
	input wire logic point_sel_bit1,
	input wire logic point_sel_bit2,
	input wire logic point_sel_bit3,
	input wire logic point_sel_bit4,
	input wire logic point_sel_bit5,
	input wire logic cmd_strobe,
	input wire logic alarm_active,
	input wire logic motion_done,
	input wire logic motion_abort,
	input wire logic decelerating,
	input wire logic decel_time_zero,
	input wire logic [15:0] deviation_abs,
	input wire logic abs_mode,
	input wire logic brake_release_req,
	input wire logic motor_moving,
	output logic fault_out,
	output logic shared_status_out,
	output logic busy_out,
	output logic cur_point_bit0,
	output logic cur_point_bit1,
	output logic cur_point_bit2,
	output logic cur_point_bit3,
	output logic cur_point_bit4,
	output logic cur_point_bit5,
	output logic brake_release_out,
	output logic cmd_start,
	output logic [2:0] cmd_kind,
	output logic [5:0] cmd_step,
	output logic alarm_clear
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [6:0] pins_s;
	pci_sync #(.WIDTH(7)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.din({cmd_strobe, point_sel_bit5, point_sel_bit4, point_sel_bit3,
			point_sel_bit2, point_sel_bit1, point_sel_bit0}),
		.dout(pins_s)
	);

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [4:0] cfg, next_cfg;
	logic [15:0] range_cfg, next_range_cfg;
	logic [15:0] brake_cfg, next_brake_cfg;
	logic [1:0] point_count_cfg;
	logic point_logic_cfg, shared_status_select_cfg, homing_disable_cfg;
	logic [7:0] brake_delay_standstill_cfg, brake_delay_moving_cfg;
	assign point_count_cfg = cfg[PCI_CFG_CNT_LSB +: 2];
	assign point_logic_cfg = cfg[PCI_CFG_LOGIC_BIT];
	assign shared_status_select_cfg = cfg[PCI_CFG_SEL_BIT];
	assign homing_disable_cfg = cfg[PCI_CFG_HDIS_BIT];
	assign brake_delay_standstill_cfg = brake_cfg[PCI_BRK_STILL_LSB +: 8];
	assign brake_delay_moving_cfg = brake_cfg[PCI_BRK_MOVE_LSB +: 8];

	// ------------------------------------------------------------
	// point decode
	// ------------------------------------------------------------
	// bit count is setting+3, so the top code moves with the setting
	logic [5:0] max_pt, sel_pt;
	logic strobe_on, strobe_q, strobe_rise;
	assign max_pt = 6'h3F >> (PCI_CNT_SIX_BITS - point_count_cfg);
	// with logic setting 1 a one on a synchronised pin is a closed contact; setting 0 inverts it
	assign sel_pt = (point_logic_cfg ? pins_s[5:0] : ~pins_s[5:0])
		& max_pt;
	assign strobe_on = pins_s[6];
	assign strobe_rise = strobe_on && !strobe_q;

	function automatic pci_kind_e pci_decode(input logic [5:0] pt,
		input logic [5:0] mx);
		pci_kind_e k;
		k = PCI_K_STEP;
		if (pt == 6'h00)
			k = PCI_K_CLEAR;
		else if (pt == mx)
			k = PCI_K_HOME;
		else if (pt == mx - 6'h01)
			k = PCI_K_JOG_POS;
		else if (pt == mx - 6'h02)
			k = PCI_K_JOG_NEG;
		return k;
	endfunction

	// ------------------------------------------------------------
	// command sequencer
	// ------------------------------------------------------------
	pci_state_e state, next_state;
	logic [5:0] cmd_pt, next_cmd_pt;
	logic [2:0] next_cmd_kind;
	logic next_cmd_start, next_alarm_clear, next_strobe_q;
	logic next_busy;

	always_comb begin
		next_state = state;
		next_cmd_pt = cmd_pt;
		next_cmd_kind = cmd_kind;
		next_cmd_start = 1'b0;
		next_alarm_clear = 1'b0;
		next_strobe_q = strobe_on;
		case (state)
			PCI_IDLE: begin
				// point is taken only on the strobe edge, one start or one alarm clear each
				if (strobe_rise) begin
					next_cmd_pt = sel_pt;
					next_cmd_kind = pci_decode(sel_pt, max_pt);
					if (sel_pt == 6'h00) begin
						next_alarm_clear = 1'b1;
						next_state = PCI_HOLD;
					end else begin
						next_cmd_start = 1'b1;
						next_state = PCI_RUN;
					end
				end
			end
			PCI_RUN: begin
				if (motion_done || motion_abort)
					next_state = PCI_HOLD;
			end
			PCI_HOLD: begin
				if (!strobe_on)
					next_state = PCI_IDLE;
			end
			default: next_state = PCI_IDLE;
		endcase
		// transistor off (0) from strobe edge until strobe opens
		next_busy = (next_state == PCI_IDLE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= PCI_IDLE;
			cmd_pt <= 6'h00;
			cmd_kind <= PCI_K_CLEAR;
			cmd_start <= 1'b0;
			alarm_clear <= 1'b0;
			strobe_q <= 1'b0;
			busy_out <= 1'b1;
		end else begin
			state <= next_state;
			cmd_pt <= next_cmd_pt;
			cmd_kind <= next_cmd_kind;
			cmd_start <= next_cmd_start;
			alarm_clear <= next_alarm_clear;
			strobe_q <= next_strobe_q;
			busy_out <= next_busy;
		end
	end
	assign cmd_step = cmd_pt;

	// ------------------------------------------------------------
	// present position
	// ------------------------------------------------------------
	// power-on value is caught one edge after release, not under reset
	logic [5:0] pos, next_pos, pos_pins, next_pos_pins;
	logic init_done, next_init_done;
	logic done_ok;
	assign done_ok = (state == PCI_RUN) && motion_done && !motion_abort;

	always_comb begin
		next_pos = pos;
		next_init_done = 1'b1;
		if (!init_done) begin
			if (abs_mode || homing_disable_cfg)
				next_pos = max_pt;
		end else if (done_ok) begin
			case (cmd_kind)
				PCI_K_STEP: next_pos = cmd_pt;
				PCI_K_HOME: next_pos = max_pt;
				PCI_K_JOG_POS: next_pos = max_pt - 6'h01;
				PCI_K_JOG_NEG: next_pos = max_pt - 6'h02;
				default: next_pos = pos;
			endcase
		end
		// an abort leaves pos untouched
		next_pos_pins = alarm_active ? 6'h00 : next_pos;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos <= 6'h00;
			pos_pins <= 6'h00;
			init_done <= 1'b0;
		end else begin
			pos <= next_pos;
			pos_pins <= next_pos_pins;
			init_done <= next_init_done;
		end
	end
	assign {cur_point_bit5, cur_point_bit4, cur_point_bit3, cur_point_bit2,
		cur_point_bit1, cur_point_bit0} = pos_pins;

	// ------------------------------------------------------------
	// status pins
	// ------------------------------------------------------------
	logic next_fault, next_shared;
	always_comb begin
		next_fault = !alarm_active;
		if (shared_status_select_cfg)
			next_shared = decelerating && !decel_time_zero;
		else
			next_shared = (deviation_abs <= range_cfg)
				&& (next_state == PCI_IDLE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_out <= 1'b0;
			shared_status_out <= 1'b0;
		end else begin
			fault_out <= next_fault;
			shared_status_out <= next_shared;
		end
	end

	// ------------------------------------------------------------
	// brake release with millisecond delays
	// ------------------------------------------------------------
	// delay runs only after the release request drops; the delay in use
	// is chosen by whether the motor turns in the last cycle the request is still high
	logic [16:0] ms_cnt, next_ms_cnt;
	logic [7:0] brk_cnt, next_brk_cnt;
	logic next_brake;
	logic ms_tick;
	assign ms_tick = (ms_cnt == 17'(MS_CYCLES - 1));

	always_comb begin
		next_ms_cnt = ms_tick ? 17'h00000 : ms_cnt + 17'h00001;
		next_brk_cnt = brk_cnt;
		next_brake = brake_release_out;
		if (brake_release_req) begin
			next_brake = 1'b1;
			next_brk_cnt = motor_moving ? brake_delay_moving_cfg
				: brake_delay_standstill_cfg;
		end else if (brake_release_out) begin
			if (brk_cnt == 8'h00)
				next_brake = 1'b0;
			else if (ms_tick)
				next_brk_cnt = brk_cnt - 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt <= 17'h00000;
			brk_cnt <= 8'h00;
			brake_release_out <= 1'b0;
		end else begin
			ms_cnt <= next_ms_cnt;
			brk_cnt <= next_brk_cnt;
			brake_release_out <= next_brake;
		end
	end

	// ------------------------------------------------------------
	// apb slave, answer registered in the setup cycle (no wait)
	// ------------------------------------------------------------
	logic setup, wr_acc, hit;
	logic [31:0] rd_val, next_prdata;
	logic next_pready, next_pslverr;
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite && pready;

	always_comb begin
		hit = 1'b1;
		rd_val = 32'h00000000;
		case (paddr)
			PCI_CFG_OFS: rd_val = {27'h0000000, cfg};
			PCI_RANGE_OFS: rd_val = {16'h0000, range_cfg};
			PCI_BRAKE_OFS: rd_val = {16'h0000, brake_cfg};
			PCI_STAT_OFS: rd_val = {21'h000000, state, fault_out,
				busy_out, pos_pins};
			PCI_CMD_OFS: rd_val = {23'h000000, cmd_kind, cmd_pt};
			default: hit = 1'b0;
		endcase
		next_pready = setup;
		next_pslverr = setup && !hit;
		next_prdata = (setup && !pwrite) ? rd_val : 32'h00000000;
		next_cfg = cfg;
		next_range_cfg = range_cfg;
		next_brake_cfg = brake_cfg;
		if (wr_acc && paddr == PCI_CFG_OFS)
			next_cfg = pwdata[4:0];
		if (wr_acc && paddr == PCI_RANGE_OFS)
			next_range_cfg = pwdata[15:0];
		if (wr_acc && paddr == PCI_BRAKE_OFS)
			next_brake_cfg = pwdata[15:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= PCI_CFG_RST;
			range_cfg <= PCI_RANGE_RST;
			brake_cfg <= PCI_BRAKE_RST;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			cfg <= next_cfg;
			range_cfg <= next_range_cfg;
			brake_cfg <= next_brake_cfg;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence strobe_edge_s;
		(state == PCI_IDLE) && strobe_rise && sel_pt != 6'h00;
	endsequence
	sequence start_pulse_s;
		cmd_start && !busy_out;
	endsequence

	strobe_start_a: assert property (strobe_edge_s |=> start_pulse_s ##1
		!cmd_start) else $error("strobe did not start one command");
	clear_decode_a: assert property ((state == PCI_IDLE) && strobe_rise
		&& sel_pt == 6'h00 |=> alarm_clear && cmd_start == 1'b0)
		else $error("point zero did not clear alarm");
	home_decode_a: assert property ((state == PCI_IDLE) && strobe_rise
		&& sel_pt == max_pt |=> cmd_kind == PCI_K_HOME)
		else $error("top code not homing");
	busy_hold_a: assert property ((state == PCI_HOLD) && strobe_on
		|=> !busy_out) else $error("busy back before strobe open");
	fault_pin_a: assert property (alarm_active |=> !fault_out)
		else $error("fault pin on during alarm");
	alarm_pos_a: assert property (alarm_active |=> pos_pins == 6'h00)
		else $error("position pins on during alarm");
	jog_pos_a: assert property (done_ok && init_done
		&& cmd_kind == PCI_K_JOG_POS && !alarm_active
		|=> pos_pins == $past(max_pt) - 6'h01)
		else $error("positive jog position wrong");
	abort_hold_a: assert property ((state == PCI_RUN) && motion_abort
		&& init_done && !alarm_active ##1 !alarm_active
		|-> pos_pins == $past(pos_pins))
		else $error("abort changed position");
	decel_pin_a: assert property (shared_status_select_cfg
		&& decel_time_zero |=> !shared_status_out)
		else $error("decelerating shown at zero time");
	in_position_out_busy_a: assert property (!shared_status_select_cfg
		&& state == PCI_RUN ##1 state == PCI_RUN |-> !shared_status_out)
		else $error("completion shown while busy");
endmodule

/* File: test/pci_host_model.sv */
// host controller model: drives the point contacts and the strobe
// assumes the drive answers a strobe by turning busy_out off
`timescale 1ns/1ns
module pci_host_model #(
	parameter int WAIT_CYC = 40
) (
	input wire logic pclk,
	input wire logic busy_out,
	output logic [5:0] point_sel,
	output logic cmd_strobe
);
	initial begin
		point_sel = 6'h00;
		cmd_strobe = 1'b0;
	end
	// contacts settle before the strobe closes; no shortcut for speed
	task automatic press(input logic [5:0] pins);
		int k;
		@(posedge pclk);
		point_sel <= pins;
		repeat (WAIT_CYC) @(posedge pclk);
		cmd_strobe <= 1'b1;
		k = 0;
		while ((k < WAIT_CYC || busy_out !== 1'b0) && k < 500) begin
			@(posedge pclk);
			k++;
		end
	endtask
	task automatic release_stb();
		@(posedge pclk);
		cmd_strobe <= 1'b0;
	endtask
endmodule

/* File: test/pci_top_tb.sv */
// self-checking bench for the point command block
// assumes the host model drives the contacts, the bench the rest
`timescale 1ns/1ns
module pci_top_tb
	import pci_pkg::*;
;
	localparam int MS = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic re;
	logic alarm_active, motion_done, motion_abort, decelerating;
	logic decel_time_zero, abs_mode, brake_release_req, motor_moving;
	logic [15:0] deviation_abs;
	logic fault_out, shared_status_out, busy_out, brake_release_out;
	logic cmd_start, alarm_clear;
	logic [2:0] cmd_kind;
	logic [5:0] cmd_step;
	wire [5:0] pins;
	wire [5:0] cur;
	wire stb;
	int mismatches = 0;
	int n_compared = 0;
	int n_starts = 0;
	int n_clears = 0;
	int cycles = 0;

	pci_top #(.MS_CYCLES(MS)) pci_top_i (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .point_sel_bit0(pins[0]),
		.point_sel_bit1(pins[1]), .point_sel_bit2(pins[2]),
		.point_sel_bit3(pins[3]), .point_sel_bit4(pins[4]),
		.point_sel_bit5(pins[5]), .cmd_strobe(stb),
		.alarm_active(alarm_active), .motion_done(motion_done),
		.motion_abort(motion_abort), .decelerating(decelerating),
		.decel_time_zero(decel_time_zero), .deviation_abs(deviation_abs),
		.abs_mode(abs_mode), .brake_release_req(brake_release_req),
		.motor_moving(motor_moving), .fault_out(fault_out),
		.shared_status_out(shared_status_out), .busy_out(busy_out),
		.cur_point_bit0(cur[0]), .cur_point_bit1(cur[1]),
		.cur_point_bit2(cur[2]), .cur_point_bit3(cur[3]),
		.cur_point_bit4(cur[4]), .cur_point_bit5(cur[5]),
		.brake_release_out(brake_release_out), .cmd_start(cmd_start),
		.cmd_kind(cmd_kind), .cmd_step(cmd_step), .alarm_clear(alarm_clear));

	pci_host_model #(.WAIT_CYC(PCI_HOST_SETUP_MS * MS)) pci_host_model_i (
		.pclk(pclk), .busy_out(busy_out), .point_sel(pins),
		.cmd_strobe(stb));

	// ----
	// clock, pulse counters, hang guard
	// ----
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cmd_start === 1'b1) n_starts <= n_starts + 1;
		if (alarm_clear === 1'b1) n_clears <= n_clears + 1;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	// ----
	// shared tasks
	// ----
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg,
				got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic wait_busy();
		int k;
		k = 0;
		while (busy_out !== 1'b1 && k < 100) begin
			@(posedge pclk);
			k++;
		end
		check(busy_out, 1'b1, "busy back after strobe open");
	endtask
	task automatic do_reset(input logic am);
		abs_mode <= am;
		presetn <= 1'b0;
		wait_cyc(10);
		presetn <= 1'b1;
		wait_cyc(3);
		check(cur, am ? 6'h3F : 6'h00, "power-on position");
		check(fault_out, 1'b1, "fault pin on, no alarm");
	endtask
	// one full command; clear has no motion to finish
	task automatic run_cmd(input logic [5:0] p, input logic [2:0] kind,
		input logic [5:0] step, input logic [5:0] pos);
		int s;
		int c;
		s = n_starts;
		c = n_clears;
		pci_host_model_i.press(p);
		check(busy_out, 1'b0, "busy off");
		check(shared_status_out, 1'b0, "completion off while busy");
		if (kind != PCI_K_CLEAR) begin
			check(cmd_kind, kind, "kind");
			check(cmd_step, step, "step");
			motion_done <= 1'b1;
			@(posedge pclk);
			motion_done <= 1'b0;
			wait_cyc(3);
			check(busy_out, 1'b0, "busy held");
		end
		check(cur, pos, "position");
		pci_host_model_i.release_stb();
		wait_busy();
		check(n_starts - s, kind != PCI_K_CLEAR, "one start");
		check(n_clears - c, kind == PCI_K_CLEAR, "one clear");
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_regs();
		apb(1'b0, PCI_CFG_OFS, 32'h0);
		check(rv, 32'h07, "cfg reset");
		apb(1'b0, PCI_RANGE_OFS, 32'h0);
		check(rv, 32'h0A, "range reset");
		apb(1'b1, PCI_BRAKE_OFS, 32'h0201);
		apb(1'b0, PCI_BRAKE_OFS, 32'h0);
		check(rv, 32'h0201, "brake readback");
		apb(1'b0, 8'h20, 32'h0);
		check(re, 1'b1, "unmapped error");
		check(rv, 32'h0, "unmapped data");
		$display("test regs done");
	endtask
	task automatic t_codes();
		logic [5:0] tp[6] = '{6'h01, 6'h3C, 6'h3D, 6'h3E, 6'h3F, 6'h00};
		logic [2:0] tk[6] = '{PCI_K_STEP, PCI_K_STEP, PCI_K_JOG_NEG,
			PCI_K_JOG_POS, PCI_K_HOME, PCI_K_CLEAR};
		logic [5:0] tq[6] = '{6'h01, 6'h3C, 6'h3D, 6'h3E, 6'h3F, 6'h3F};
		for (int i = 0; i < 6; i++) begin
			run_cmd(tp[i], tk[i], tp[i], tq[i]);
		end
		$display("test codes done");
	endtask
	task automatic t_cfg();
		apb(1'b1, PCI_CFG_OFS, 32'h04);
		run_cmd(6'h07, PCI_K_HOME, 6'h07, 6'h07);
		run_cmd(6'h06, PCI_K_JOG_POS, 6'h06, 6'h06);
		run_cmd(6'h05, PCI_K_JOG_NEG, 6'h05, 6'h05);
		apb(1'b1, PCI_CFG_OFS, 32'h03);
		run_cmd(6'h3A, PCI_K_STEP, 6'h05, 6'h05);
		apb(1'b1, PCI_CFG_OFS, 32'h07);
		$display("test cfg done");
	endtask
	task automatic t_fault();
		alarm_active <= 1'b1;
		wait_cyc(3);
		check(fault_out, 1'b0, "fault pin off");
		check(cur, 6'h00, "pins off on alarm");
		alarm_active <= 1'b0;
		wait_cyc(3);
		check(cur, 6'h05, "position back");
		pci_host_model_i.press(6'h09);
		motion_abort <= 1'b1;
		@(posedge pclk);
		motion_abort <= 1'b0;
		wait_cyc(3);
		check(cur, 6'h05, "abort holds position");
		pci_host_model_i.release_stb();
		wait_busy();
		$display("test fault done");
	endtask
	task automatic t_status();
		deviation_abs <= 16'h0005;
		wait_cyc(4);
		check(shared_status_out, 1'b1, "in range");
		deviation_abs <= 16'h000B;
		wait_cyc(4);
		check(shared_status_out, 1'b0, "out of range");
		apb(1'b1, PCI_CFG_OFS, 32'h0F);
		decelerating <= 1'b1;
		wait_cyc(4);
		check(shared_status_out, 1'b1, "decelerating");
		decel_time_zero <= 1'b1;
		wait_cyc(4);
		check(shared_status_out, 1'b0, "zero decel time");
		decelerating <= 1'b0;
		apb(1'b1, PCI_CFG_OFS, 32'h07);
		$display("test status done");
	endtask
	// delays are 1 ms still, 2 ms moving; only the bound is checked
	task automatic t_brake();
		int k;
		brake_release_req <= 1'b1;
		k = 0;
		while (brake_release_out !== 1'b1 && k < 100) begin
			@(posedge pclk);
			k++;
		end
		check(brake_release_out, 1'b1, "brake released");
		motor_moving <= 1'b1;
		brake_release_req <= 1'b0;
		wait_cyc(2);
		check(brake_release_out, 1'b1, "brake held in delay");
		wait_cyc(100);
		check(brake_release_out, 1'b0, "brake engaged");
		$display("test brake done");
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{alarm_active, motion_done, motion_abort, decelerating} = '0;
		{decel_time_zero, abs_mode, brake_release_req} = '0;
		motor_moving = 1'b0;
		deviation_abs = 16'h0000;
		do_reset(1'b1);
		do_reset(1'b0);
		t_regs();
		t_codes();
		t_cfg();
		t_fault();
		t_status();
		t_brake();
		wrap_up();
	end
endmodule
